// ### hw/ddb_framer_pkg.sv
// Constants for the download data block packet framer.
`default_nettype none
package ddb_framer_pkg;
	localparam int PKT_LEN = 188;
	localparam logic [7:0] POS_LAST = 8'hBB;
	localparam logic [7:0] POS_DATA = 8'h1F;
	localparam logic [7:0] CKSUM_LEN = 8'h04;
	localparam logic [7:0] MAX_DATA = 8'h99;
	localparam logic [11:0] SEC_LEN_BASE = 12'h01B;
	localparam logic [15:0] MSG_LEN_BASE = 16'h0006;
	localparam logic [7:0] SYNC_BYTE = 8'h47;
	localparam logic [1:0] SCRAMBLE_NONE = 2'h0;
	localparam logic [1:0] AFC_PAYLOAD = 2'h1;
	localparam logic [7:0] POINTER_VAL = 8'h00;
	localparam logic [7:0] TABLE_DDB = 8'h3C;
	localparam logic [1:0] SYNTAX_PRIV = 2'h1;
	localparam logic [1:0] RSV2 = 2'h3;
	localparam logic [7:0] RSV8 = 8'hFF;
	localparam logic [7:0] PROTO_DISC = 8'h11;
	localparam logic [7:0] MSG_TYPE = 8'h03;
	localparam logic [15:0] MSG_ID_DDB = 16'h1003;
	localparam logic [7:0] ADAPT_NONE = 8'h00;
	localparam logic [7:0] CKSUM_BYTE = 8'h00;
	localparam logic [7:0] STUFF_BYTE = 8'hFF;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 16;
	typedef enum logic {ST_IDLE, ST_RUN} frame_state_t;
endpackage
`default_nettype wire

// ### hw/ddb_framer.sv
// Data FIFO and packet framer for one download data block section.
// Contract
// - Payload unit start indicator is one, since the section begins here.
// - Adaptation field control is 01b, payload only.
// - Scrambling control is 00b, unscrambled.
// - Pointer byte 0x00 follows the transport header.
// - Section starts with table identifier 0x3C.
// - Section syntax indicator 0b, private indicator 1b.
// - All reserved fields are sent as ones.
// - Section length counts table-id extension through last checksum byte.
// - Table-id extension repeats the module identifier.
// - Version number repeats low five bits of module version.
// - Current/next indicator is always one.
// - Section number is block low byte; last is highest number coded.
// - Download identifier carries the carousel identifier.
// - Adaptation length is 0x00, no timestamp.
// - Message length counts the bytes following it up to the last data byte, not the checksum.
// - Body module identifier names the block's module.
// - Block number gives position in module, zero first.
// - Block number is followed by N file bytes.
// - Section ends with 32-bit checksum, all zero meaning none.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	output logic [WIDTH-1:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic next_wr_ready, push, pop;

	always_comb begin
		push = wr_valid && wr_ready;
		pop = rd_valid && rd_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
		next_wr_ready = (next_count < (AW+1)'(DEPTH));
		rd_valid = (count != '0);
		rd_data = mem[rd_ptr];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			wr_ready <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			wr_ready <= next_wr_ready;
		end
		if (push) begin
			mem[wr_ptr] <= wr_data;
		end
	end
endmodule
////////////////////////////////////////////////////////////////////////////////
module ddb_framer import ddb_framer_pkg::*; (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [12:0] pid,
	input wire logic [3:0] cont_count,
	input wire logic [15:0] module_id,
	input wire logic [7:0] module_version,
	input wire logic [15:0] block_number,
	input wire logic [31:0] carousel_id,
	input wire logic [7:0] data_len,
	output logic busy,
	input wire logic [7:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [7:0] out_data,
	output logic out_valid,
	output logic out_sop,
	output logic out_eop,
	input wire logic out_ready
);
	frame_state_t state, next_state;
	logic [12:0] pkt_pid, next_pkt_pid;
	logic [3:0] pkt_cc, next_pkt_cc;
	logic [15:0] mod_id, next_mod_id, blk_num, next_blk_num;
	logic [7:0] mod_ver, next_mod_ver, n_bytes, next_n_bytes;
	logic [31:0] dl_id, next_dl_id;
	logic [7:0] last_sec, next_last_sec, max_sec, next_max_sec;
	logic [15:0] prev_mod, next_prev_mod;
	logic have_mod, next_have_mod;
	logic [7:0] idx, next_idx, idx_out, next_idx_out;
	logic [7:0] next_out_data, byte_val, data_end, ck_end, blk_lo, clamp_len;
	logic next_out_valid, next_out_sop, next_out_eop, next_busy;
	logic [11:0] sec_len;
	logic [15:0] msg_len;
	logic is_data, load, fifo_valid;
	logic [7:0] fifo_data;

	// The FIFO lets the source run ahead of the header bytes; it stalls via in_ready.
	byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) data_fifo (
		.clk(core_clk),
		.rst(sys_rst),
		.wr_data(in_data),
		.wr_valid(in_valid),
		.wr_ready(in_ready),
		.rd_data(fifo_data),
		.rd_valid(fifo_valid),
		.rd_ready(load && is_data)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		data_end = POS_DATA + n_bytes;
		ck_end = data_end + CKSUM_LEN;
		sec_len = SEC_LEN_BASE + {4'h0, n_bytes};
		msg_len = MSG_LEN_BASE + {8'h00, n_bytes};
		is_data = (idx >= POS_DATA) && (idx < data_end);
		byte_val = STUFF_BYTE;
		case (idx)
			8'h00: byte_val = SYNC_BYTE;
			8'h01: byte_val = {1'b0, 1'b1, 1'b0, pkt_pid[12:8]};
			8'h02: byte_val = pkt_pid[7:0];
			8'h03: byte_val = {SCRAMBLE_NONE, AFC_PAYLOAD, pkt_cc};
			8'h04: byte_val = POINTER_VAL;
			8'h05: byte_val = TABLE_DDB;
			8'h06: byte_val = {SYNTAX_PRIV, RSV2, sec_len[11:8]};
			8'h07: byte_val = sec_len[7:0];
			8'h08: byte_val = mod_id[15:8];
			8'h09: byte_val = mod_id[7:0];
			8'h0A: byte_val = {RSV2, mod_ver[4:0], 1'b1};
			8'h0B: byte_val = blk_num[7:0];
			8'h0C: byte_val = last_sec;
			8'h0D: byte_val = PROTO_DISC;
			8'h0E: byte_val = MSG_TYPE;
			8'h0F: byte_val = MSG_ID_DDB[15:8];
			8'h10: byte_val = MSG_ID_DDB[7:0];
			8'h11: byte_val = dl_id[31:24];
			8'h12: byte_val = dl_id[23:16];
			8'h13: byte_val = dl_id[15:8];
			8'h14: byte_val = dl_id[7:0];
			8'h15: byte_val = RSV8;
			8'h16: byte_val = ADAPT_NONE;
			8'h17: byte_val = msg_len[15:8];
			8'h18: byte_val = msg_len[7:0];
			8'h19: byte_val = mod_id[15:8];
			8'h1A: byte_val = mod_id[7:0];
			8'h1B: byte_val = mod_ver;
			8'h1C: byte_val = RSV8;
			8'h1D: byte_val = blk_num[15:8];
			8'h1E: byte_val = blk_num[7:0];
			default: begin
				if (is_data) begin
					byte_val = fifo_data;
				end else if (idx >= data_end && idx < ck_end) begin
					byte_val = CKSUM_BYTE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		blk_lo = block_number[7:0];
		clamp_len = (data_len > MAX_DATA) ? MAX_DATA : data_len;
		load = (state == ST_RUN) && (!out_valid || out_ready) && (!is_data || fifo_valid);
		next_state = state;
		next_pkt_pid = pkt_pid;
		next_pkt_cc = pkt_cc;
		next_mod_id = mod_id;
		next_mod_ver = mod_ver;
		next_blk_num = blk_num;
		next_dl_id = dl_id;
		next_n_bytes = n_bytes;
		next_last_sec = last_sec;
		next_max_sec = max_sec;
		next_prev_mod = prev_mod;
		next_have_mod = have_mod;
		next_idx = idx;
		next_idx_out = idx_out;
		next_busy = busy;
		next_out_data = out_data;
		next_out_valid = out_valid && !out_ready;
		next_out_sop = out_sop;
		next_out_eop = out_eop;
		case (state)
			ST_IDLE: begin
				if (start) begin
					next_state = ST_RUN;
					next_busy = 1'b1;
					next_idx = 8'h00;
					next_pkt_pid = pid;
					next_pkt_cc = cont_count;
					next_mod_id = module_id;
					next_mod_ver = module_version;
					next_blk_num = block_number;
					next_dl_id = carousel_id;
					next_n_bytes = clamp_len;
					// A new module restarts the running maximum of block numbers.
					if (!have_mod || module_id != prev_mod || blk_lo > max_sec) begin
						next_max_sec = blk_lo;
					end
					next_last_sec = next_max_sec;
					next_prev_mod = module_id;
					next_have_mod = 1'b1;
				end
			end
			ST_RUN: begin
				if (load) begin
					next_out_data = byte_val;
					next_out_valid = 1'b1;
					next_out_sop = (idx == 8'h00);
					next_out_eop = (idx == POS_LAST);
					next_idx_out = idx;
					next_idx = idx + 8'h01;
					if (idx == POS_LAST) begin
						next_state = ST_IDLE;
						next_busy = 1'b0;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			pkt_pid <= '0;
			pkt_cc <= '0;
			mod_id <= '0;
			mod_ver <= '0;
			blk_num <= '0;
			dl_id <= '0;
			n_bytes <= '0;
			last_sec <= '0;
			max_sec <= '0;
			prev_mod <= '0;
			have_mod <= 1'b0;
			idx <= '0;
			idx_out <= '0;
			busy <= 1'b0;
			out_data <= '0;
			out_valid <= 1'b0;
			out_sop <= 1'b0;
			out_eop <= 1'b0;
		end else begin
			state <= next_state;
			pkt_pid <= next_pkt_pid;
			pkt_cc <= next_pkt_cc;
			mod_id <= next_mod_id;
			mod_ver <= next_mod_ver;
			blk_num <= next_blk_num;
			dl_id <= next_dl_id;
			n_bytes <= next_n_bytes;
			last_sec <= next_last_sec;
			max_sec <= next_max_sec;
			prev_mod <= next_prev_mod;
			have_mod <= next_have_mod;
			idx <= next_idx;
			idx_out <= next_idx_out;
			busy <= next_busy;
			out_data <= next_out_data;
			out_valid <= next_out_valid;
			out_sop <= next_out_sop;
			out_eop <= next_out_eop;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks on the presented byte, keyed to its position in the packet, besides the stall hold and end-of-packet busy checks.
	AST_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("output byte changed while stalled");
	AST_PUSI: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && idx_out == 8'h01 |-> out_data[7:5] == 3'b010)
		else $error("start indicator wrong");
	AST_AFC: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && idx_out == 8'h03 |-> out_data[5:4] == 2'b01)
		else $error("adaptation field control wrong");
	AST_TSC: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && idx_out == 8'h03 |-> out_data[7:6] == 2'b00)
		else $error("scrambling control wrong");
	AST_PTR_TID: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && out_ready && idx_out == 8'h04 |->
		out_data == 8'h00 ##1 (!out_valid || out_data == 8'h3C))
		else $error("pointer or table identifier wrong");
	AST_TID: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && idx_out == 8'h05 |-> out_data == 8'h3C)
		else $error("table identifier wrong");
	AST_SYNTAX: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && idx_out == 8'h06 |-> out_data[7:4] == 4'h7)
		else $error("syntax bits wrong");
	AST_RSV: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && (idx_out == 8'h15 || idx_out == 8'h1C) |-> out_data == 8'hFF)
		else $error("reserved byte not ones");
	AST_SECLEN: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && idx_out == 8'h07 |-> out_data == 8'(n_bytes + 8'h1B))
		else $error("section length wrong");
	AST_CNI: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && idx_out == 8'h0A |-> out_data[7:6] == 2'b11 && out_data[0])
		else $error("current indicator wrong");
	AST_ADAPT: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && idx_out == 8'h16 |-> out_data == 8'h00)
		else $error("adaptation length wrong");
	// A start taken while the last byte still stands reloads the lengths, so skip that byte.
	AST_CKSUM: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && !(out_eop && busy) && idx_out >= data_end && idx_out < ck_end |->
		out_data == 8'h00)
		else $error("checksum byte not zero");
	AST_PAD: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && !(out_eop && busy) && idx_out >= ck_end |-> out_data == 8'hFF)
		else $error("padding byte not 0xFF");
	AST_EOP: assert property (@(posedge core_clk) disable iff (sys_rst)
		out_valid && out_eop |-> idx_out == 8'hBB)
		else $error("end of packet misplaced");
	AST_EOP_IDLE: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(out_eop) |-> out_valid && !busy)
		else $error("busy still high at end of packet");
endmodule
`default_nettype wire

// ### bench/ts_sink_model.sv
// Behavioural transport stream multiplexer that accepts framed packet bytes.
`default_nettype none
module ts_sink_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic [7:0] out_data,
	input wire logic out_valid,
	input wire logic out_sop,
	input wire logic out_eop,
	output logic out_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] pkt [188];
	int idx = 0;
	int npkt = 0;
	int bad = 0;
	// A slow multiplexer stalls every other cycle, so held outputs get exercised.
	always @(posedge clk) begin
		if (rst) begin
			out_ready <= 1'b0;
			idx = 0;
		end else begin
			out_ready <= slow ? ~out_ready : 1'b1;
			if (out_valid && out_ready) begin
				pkt[idx] = out_data;
				if (out_sop !== (idx == 0) || out_eop !== (idx == 187)) bad++;
				idx = (idx == 187) ? 0 : idx + 1;
				if (idx == 0) npkt++;
			end
		end
	end
endmodule
`default_nettype wire

// ### bench/ddb_framer_tb_top.sv
// Self-checking bench for the download data block packet framer.
`default_nettype none
module ddb_framer_tb_top import ddb_framer_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [15:0] mid;
		logic [7:0] ver;
		logic [15:0] blk;
		logic [31:0] car;
		logic [7:0] len;
		logic slow;
	} row_t;
	logic core_clk = 1'b0, sys_rst = 1'b1, start = 1'b0, in_valid = 1'b0, slow = 1'b0;
	logic [12:0] pid = 13'h0000;
	logic [3:0] cont_count = 4'h0;
	logic [15:0] module_id = 16'h0000, block_number = 16'h0000, last_mid;
	logic [7:0] module_version = 8'h00, data_len = 8'h00, in_data = 8'h00, mx;
	logic [31:0] carousel_id = 32'h0;
	logic have = 1'b0;
	wire logic busy, in_ready, out_valid, out_sop, out_eop, out_ready;
	wire logic [7:0] out_data;
	int errors = 0;
	int compares = 0;
	row_t rows [7] = '{
		'{16'h0003, 8'h00, 16'h0000, 32'h00000000, 8'h3D, 1'b0},
		'{16'h0003, 8'h22, 16'h0105, 32'h12345678, 8'h00, 1'b1},
		'{16'h0003, 8'h3F, 16'h0002, 32'hABCDEF01, 8'h10, 1'b0},
		'{16'h0007, 8'h1F, 16'h01FF, 32'hFFFFFFFF, 8'h99, 1'b1},
		'{16'h0007, 8'h00, 16'h0010, 32'h0F0F0F0F, 8'hC8, 1'b0},
		'{16'h0009, 8'h41, 16'h0003, 32'h2468ACE0, 8'h40, 1'b1},
		'{16'h0009, 8'h05, 16'h0020, 32'h13579BDF, 8'h10, 1'b1}};
	ddb_framer DUT (.core_clk(core_clk), .sys_rst(sys_rst), .start(start), .pid(pid),
		.cont_count(cont_count), .module_id(module_id), .module_version(module_version),
		.block_number(block_number), .carousel_id(carousel_id), .data_len(data_len),
		.busy(busy), .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
		.out_data(out_data), .out_valid(out_valid), .out_sop(out_sop), .out_eop(out_eop),
		.out_ready(out_ready));
	ts_sink_model SINK (.clk(core_clk), .rst(sys_rst), .slow(slow), .out_data(out_data),
		.out_valid(out_valid), .out_sop(out_sop), .out_eop(out_eop), .out_ready(out_ready));
	////////////////////////////////////////
	initial forever #25 core_clk = ~core_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Holds valid across back-to-back bytes; the data pattern depends on the block.
	task push_range(input int a, input int b, input logic [7:0] p);
		for (int k = a; k < b; k++) begin
			in_data <= 8'(k) + p;
			in_valid <= 1'b1;
			@(posedge core_clk);
			while (in_ready !== 1'b1) @(posedge core_clk);
		end
		in_valid <= 1'b0;
	endtask
	task run_pkt(input row_t r, input int pre, input int i);
		int n, n0;
		logic [12:0] p;
		logic [3:0] c;
		logic [11:0] sl;
		logic [15:0] ml;
		logic [247:0] h;
		logic [7:0] e [188];
		n = (r.len > 8'h99) ? 153 : int'(r.len);
		if (!have || r.mid !== last_mid) mx = r.blk[7:0];
		else if (r.blk[7:0] > mx) mx = r.blk[7:0];
		have = 1'b1;
		last_mid = r.mid;
		p = 13'h1F00 | 13'(i);
		c = 4'(i + 4);
		sl = 12'h01B + 12'(n);
		ml = 16'h0006 + 16'(n);
		h = {8'h47, 3'b010, p, 4'h1, c, 8'h00, 8'h3C, 4'h7, sl, r.mid, 2'b11, r.ver[4:0],
			1'b1, r.blk[7:0], mx, 8'h11, 8'h03, 16'h1003, r.car, 8'hFF, 8'h00, ml, r.mid,
			r.ver, 8'hFF, r.blk};
		for (int k = 0; k < 188; k++) begin
			if (k < 31) e[k] = h[247 - 8 * k -: 8];
			else if (k < 31 + n) e[k] = 8'(k - 31) + r.blk[7:0];
			else if (k < 35 + n) e[k] = 8'h00;
			else e[k] = 8'hFF;
		end
		slow <= r.slow;
		pid <= p;
		cont_count <= c;
		module_id <= r.mid;
		module_version <= r.ver;
		block_number <= r.blk;
		carousel_id <= r.car;
		data_len <= r.len;
		n0 = SINK.npkt;
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		push_range(pre, n, r.blk[7:0]);
		@(posedge core_clk);
		chk(busy, 1'b1);
		while (SINK.npkt == n0) @(posedge core_clk);
		chk(busy, 1'b0);
		for (int k = 0; k < 31; k++) chk(SINK.pkt[k], e[k]);
		for (int k = 31; k < 31 + n; k++) chk(SINK.pkt[k], e[k]);
		for (int k = 31 + n; k < 188; k++) chk(SINK.pkt[k], e[k]);
		chk(SINK.bad, 0);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge core_clk);
		errors++;
		finish_test;
	end
	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk({busy, out_valid, in_ready}, 3'b001);
		for (int i = 0; i < 5; i++) run_pkt(rows[i], 0, i);
		// A start pulse in mid-packet must not produce a second packet.
		fork
			begin
				repeat (20) @(posedge core_clk);
				start <= 1'b1;
				@(posedge core_clk);
				start <= 1'b0;
			end
		join_none
		run_pkt(rows[5], 0, 5);
		repeat (400) @(posedge core_clk);
		chk(SINK.npkt, 6);
		// Fill the buffer while idle until it refuses, then let one packet drain it.
		push_range(0, 16, rows[6].blk[7:0]);
		#1;
		chk(in_ready, 1'b0);
		@(posedge core_clk);
		run_pkt(rows[6], 16, 6);
		#1;
		chk(in_ready, 1'b1);
		finish_test;
	end
endmodule
`default_nettype wire
